// [design/alloc_list_mem.v]
`timescale 1ns/100ps
`default_nettype none

// Holds the bit-number allocation list; read data is registered
module alloc_list_mem #(
  parameter DEPTH  = 16,
  parameter AW     = 4,
  parameter DW     = 6
) (
  input  wire          core_clk,
  input  wire          wr_en,
  input  wire [AW-1:0] wr_addr,
  input  wire [DW-1:0] wr_data,
  input  wire [AW-1:0] rd_addr,
  output reg  [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:DEPTH-1];

  // Synchronous write and registered read
  always @(posedge core_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// [design/drive_status_bit_packer.v]
`timescale 1ns/100ps
`default_nettype none
`include "status_packer_defines.vh"

module drive_status_bit_packer #(
  parameter PW      = 32,
  parameter ENTRIES = 16,
  parameter AW      = 4
) (
  input  wire                 core_clk,
  input  wire                 rst,
  input  wire signed [PW-1:0] target_pos,
  input  wire signed [PW-1:0] actual_pos,
  input  wire signed [PW-1:0] pos_limit_hi,
  input  wire signed [PW-1:0] pos_limit_lo,
  input  wire [63:0]          op_data,
  input  wire                 list_clear,
  input  wire                 list_wr,
  input  wire [5:0]           list_bitnum,
  input  wire [3:0]           rt_bit_sel,
  output reg  [15:0]          class1_diag_word,
  output reg  [15:0]          class2_diag_word,
  output reg  [15:0]          warn_value,
  output reg  [15:0]          signal_status_word,
  output reg  [15:0]          rt_status,
  output reg  [4:0]           list_count,
  output wire                 list_wr_refused
);

  // The five status word outputs are each one word of this width; the packed status word has one bit per list slot
  localparam SW = 16;

  // Working copy of the allocation list; read in parallel by the packer
  reg  [5:0]    entry [0:ENTRIES-1];
  // Next values of the registered outputs
  reg  [4:0]    next_count;
  reg  [15:0]   next_class1;
  reg  [15:0]   next_class2;
  reg  [15:0]   next_warn;
  wire [15:0]   next_status;
  wire [15:0]   next_rt;
  // Limit comparison results
  wire          target_above;
  wire          target_below;
  wire          target_out;
  wire          actual_above;
  wire          actual_below;
  wire          actual_out;
  // List write qualification
  wire          list_full;
  wire          bitnum_ok;
  wire          wr_ok;
  wire          list_we;
  wire [AW-1:0] wr_slot;
  // Per-bit selector index
  genvar        g;

  // Target against both limits; equal to a limit still counts as inside
  assign target_above = (target_pos > pos_limit_hi);
  assign target_below = (target_pos < pos_limit_lo);
  assign target_out   = target_above || target_below;

  // Actual position against the same limits for the shut-down flag.
  // Limits set the wrong way round flag every position; keep hi above lo.
  assign actual_above = (actual_pos > pos_limit_hi);
  assign actual_below = (actual_pos < pos_limit_lo);
  assign actual_out   = actual_above || actual_below;

  // Appends stop at sixteen entries; a six-bit number can never exceed 63
  assign list_full       = (list_count >= `ALLOC_MAX_ENTRIES);
  assign bitnum_ok       = (list_bitnum <= `ALLOC_MAX_BITNUM);
  assign wr_ok           = list_wr && !list_clear && !list_full && bitnum_ok;

  // Refusal is combinational so the writer sees it in the same cycle
  assign list_wr_refused = list_wr && !wr_ok;

  // Reset blocks the storage write as well as the count
  assign list_we = wr_ok && !rst;
  assign wr_slot = list_count[AW-1:0];

  // Clear wins over an append in the same cycle;
  // a refused write leaves the count where it was
  always @* begin
    next_count = list_count;
    if (list_clear) begin
      next_count = `ALLOC_COUNT_RESET;
    end else if (wr_ok) begin
      next_count = list_count + 5'h01;
    end
  end

  // List length; synchronous reset empties the list
  always @(posedge core_clk) begin
    if (rst) begin
      list_count <= `ALLOC_COUNT_RESET;
    end else begin
      list_count <= next_count;
    end
  end

  // Entries are appended in order, so a slot's index is its destination bit
  always @(posedge core_clk) begin
    if (list_we) begin
      entry[wr_slot] <= list_bitnum;
    end
  end

  // Shadow copy of the list, read data left unconnected; the packer uses the working copy
  // because one registered read port cannot feed sixteen selectors at once
  alloc_list_mem #(
    .DEPTH (ENTRIES),
    .AW    (AW),
    .DW    (6)
  ) u_mem (
    .core_clk (core_clk),
    .wr_en    (list_we),
    .wr_addr  (wr_slot),
    .wr_data  (list_bitnum),
    .rd_addr  ({AW{1'b0}}),
    .rd_data  ()
  );

  // One selector per status bit: packed data bit and real-time routing
  generate
    for (g = 0; g < SW; g = g + 1) begin : gen_bit
      wire       in_list;
      wire [5:0] sel_bit;
      // Slots past the storage depth hold no entry and select bit 0
      if (g < ENTRIES) begin : gen_slot
        assign sel_bit = entry[g];
      end else begin : gen_none
        assign sel_bit = 6'h00;
      end
      // Slots at or above the list length read zero, not stale entries
      assign in_list        = (g < list_count);
      assign next_status[g] = in_list ? op_data[sel_bit] : 1'b0;
      // Warning routed to the selected real-time bit only
      assign next_rt[g]     = target_out && (rt_bit_sel == g);
    end
  endgenerate

  // Class-1 word: only the overtravel shut-down flag is defined here;
  // other class-1 causes belong to other blocks and read zero
  always @* begin
    next_class1                  = `STATUS_WORD_RESET;
    next_class1[`OVERTRAVEL_BIT] = actual_out;
  end

  // Class-2 word: the target-range warning sits at its own position;
  // other class-2 warnings are reported elsewhere
  always @* begin
    next_class2                    = `STATUS_WORD_RESET;
    next_class2[`TARGET_RANGE_BIT] = target_out;
  end

  // Operation-data value: bit 0 carries the warning, the rest stay zero
  // so that no undefined attribute bit ever leaks the warning
  always @* begin
    next_warn                  = `STATUS_WORD_RESET;
    next_warn[`WARN_VALUE_BIT] = target_out;
  end

  // Flag follows the position each cycle; latching is the controller's job
  always @(posedge core_clk) begin
    if (rst) begin
      class1_diag_word <= `STATUS_WORD_RESET;
    end else begin
      class1_diag_word <= next_class1;
    end
  end

  // Class-2 word register
  always @(posedge core_clk) begin
    if (rst) begin
      class2_diag_word <= `STATUS_WORD_RESET;
    end else begin
      class2_diag_word <= next_class2;
    end
  end

  // Operation-data warning value register
  always @(posedge core_clk) begin
    if (rst) begin
      warn_value <= `STATUS_WORD_RESET;
    end else begin
      warn_value <= next_warn;
    end
  end

  // Packed status word; a new entry shows one edge after it is appended.
  // Bits above the list length are zeroed by the selectors, not here.
  always @(posedge core_clk) begin
    if (rst) begin
      signal_status_word <= `STATUS_WORD_RESET;
    end else begin
      signal_status_word <= next_status;
    end
  end

  // Real-time status register; the selector may move every cycle.
  // Only one bit can be high, so a controller may OR it with others.
  always @(posedge core_clk) begin
    if (rst) begin
      rt_status <= `STATUS_WORD_RESET;
    end else begin
      rt_status <= next_rt;
    end
  end

endmodule

`default_nettype wire

// [design/status_packer_defines.vh]
`ifndef STATUS_PACKER_DEFINES_VH
`define STATUS_PACKER_DEFINES_VH

// Class-1 diagnostic word: overtravel shut-down flag
`define OVERTRAVEL_BIT      4'hD
// Class-2 diagnostic word: target-range warning position
`define TARGET_RANGE_BIT    4'h0
// Warning value bit inside the operation data
`define WARN_VALUE_BIT      4'h0
// Allocation list limits
`define ALLOC_MAX_ENTRIES   5'h10
`define ALLOC_MAX_BITNUM    6'h3F
// Reset values
`define STATUS_WORD_RESET   16'h0000
`define ALLOC_COUNT_RESET   5'h00

`endif

// [dv/drive_status_bit_packer_chk.sv]
`timescale 1ns/100ps
`default_nettype none
module drive_status_bit_packer_chk (
  input wire logic               core_clk,
  input wire logic               rst,
  input wire logic               list_clear,
  input wire logic               list_wr,
  input wire logic               list_wr_refused,
  input wire logic signed [31:0] target_pos,
  input wire logic signed [31:0] actual_pos,
  input wire logic signed [31:0] pos_limit_hi,
  input wire logic signed [31:0] pos_limit_lo,
  input wire logic [3:0]         rt_bit_sel,
  input wire logic [4:0]         list_count,
  input wire logic [15:0]        class1_diag_word,
  input wire logic [15:0]        class2_diag_word,
  input wire logic [15:0]        warn_value,
  input wire logic [15:0]        rt_status,
  input wire logic [15:0]        signal_status_word
);
  // Equal to a limit counts as inside
  wire ot = target_pos > pos_limit_hi || target_pos < pos_limit_lo;
  wire oa = actual_pos > pos_limit_hi || actual_pos < pos_limit_lo;
  logic rst_d;
  // $past still sees reset values one edge after release
  always @(posedge core_clk) rst_d <= rst;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || rst_d);
  chk_warn_bit: assert property (class2_diag_word == {15'h0, $past(ot)})
    else $error("class2 word wrong");
  chk_over_travel: assert property (class1_diag_word == {2'h0, $past(oa), 13'h0})
    else $error("class1 word wrong");
  chk_rt_map: assert property (rt_status == ({15'h0, $past(ot)} << $past(rt_bit_sel)))
    else $error("rt status wrong");
  chk_warn_value: assert property (warn_value == class2_diag_word)
    else $error("warn value wrong");
  chk_list_add: assert property (list_wr && !list_clear && list_count < 5'h10 |=>
    list_count == $past(list_count) + 5'h01) else $error("append lost");
  chk_list_full: assert property (list_wr && !list_clear && list_count == 5'h10 |->
    list_wr_refused ##1 list_count == 5'h10) else $error("overfill taken");
  chk_list_clr: assert property (list_clear |=> list_count == 5'h00)
    else $error("clear failed");
  chk_upper_zero: assert property ((signal_status_word >> $past(list_count)) == 16'h0)
    else $error("unused bits set");
  cover property (list_wr_refused);
  cover property (class1_diag_word[13]);
  cover property (rt_status != 16'h0);
  cover property (signal_status_word != 16'h0);
endmodule
bind drive_status_bit_packer drive_status_bit_packer_chk chk (.*);
`default_nettype wire

// [dv/drive_status_bit_packer_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`define CMP(e, s) begin total_checks++; if ((e) !== (s)) begin err_count++; \
  $display("MISMATCH status exp %h got %h", e, s); end end
module drive_status_bit_packer_tb;
  localparam int L = 1000;
  logic core_clk = 0, rst = 1, list_clear = 0, list_wr = 0, look = 0;
  logic signed [31:0] tp = 0, ap = 0;
  logic [63:0] od = 0, seen, e_v, exp_q [$];
  logic [5:0] bn = 0, lst [16];
  logic [3:0] sel = 0;
  logic [15:0] c1, c2, ssw, rt;
  int err_count = 0, total_checks = 0, n = 0, j;
  drive_status_bit_packer DUT (.core_clk(core_clk), .rst(rst), .target_pos(tp),
    .actual_pos(ap), .pos_limit_hi(L), .pos_limit_lo(-L), .op_data(od),
    .list_clear(list_clear), .list_wr(list_wr), .list_bitnum(bn), .rt_bit_sel(sel),
    .class1_diag_word(c1), .class2_diag_word(c2), .warn_value(), .rt_status(rt),
    .signal_status_word(ssw), .list_count(), .list_wr_refused());
  status_reader rd (.c1(c1), .c2(c2), .rt(rt), .ssw(ssw), .seen(seen));
  initial forever #50 core_clk = ~core_clk;
  // Generous: the tests need under fifty cycles of the 5000 allowed
  initial begin
    #500000;
    err_count++;
    tally_and_finish;
  end
  // Monitor takes the oldest note when the driver flags a result
  always @(negedge core_clk) if (look === 1'b1) begin
    e_v = exp_q.pop_front();
    `CMP(e_v, seen)
  end
  task tally_and_finish;
    if (err_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Back-to-back appends; once full the extra write must be dropped
  task wr(int k);
    repeat (k) begin
      list_wr = 1;
      bn = $urandom;
      if (n < 16) lst[n] = bn;
      n = n + (n < 16);
      @(posedge core_clk) #1;
    end
    list_wr = 0;
  endtask
  task step(int k);
    logic [15:0] s;
    logic t;
    od = {$urandom, $urandom};
    sel = $urandom;
    tp = (k < 2) ? (k ? -L : L) : $urandom_range(3000) - 1500;
    ap = $urandom_range(3000) - 1500;
    s = 0;
    for (int i = 0; i < n; i++) s[i] = od[lst[i]];
    t = tp > L || tp < -L;
    @(posedge core_clk) #1;
    exp_q.push_back({2'h0, ap > L || ap < -L, 13'h0, 15'h0, t, {15'h0, t} << sel, s});
    look = 1;
    @(posedge core_clk) #1;
    look = 0;
  endtask
  initial begin
    j = $urandom(32'h65BEE77F);
    repeat (5) @(posedge core_clk);
    #1 rst = 0;
    wr(5);
    for (j = 0; j < 6; j++) step(j);
    wr(12);
    for (j = 0; j < 6; j++) step(j);
    list_clear = 1;
    @(posedge core_clk) #1;
    list_clear = 0;
    n = 0;
    step(2);
    tally_and_finish;
  end
endmodule
`default_nettype wire

// [dv/status_reader.sv]
`timescale 1ns/100ps
`default_nettype none
// Control unit view: one snapshot of every status word it reads
module status_reader (
  input  wire logic [15:0] c1,
  input  wire logic [15:0] c2,
  input  wire logic [15:0] rt,
  input  wire logic [15:0] ssw,
  output logic      [63:0] seen
);
  assign seen = {c1, c2, rt, ssw};
endmodule
`default_nettype wire
